// File: apd_pkg.sv
// constants for the inactivity sleep unit: pin indices, mode bit positions, counts
// assumes all pins are sampled on the single 10 MHz system clock
package sleep_unit_pkg;
	// system clock rate, for reference by the surrounding logic
	localparam int unsigned CLK_HZ       = 10_000_000;
	// positions in the sampled pin vector
	localparam int unsigned P_STB        = 0;
	localparam int unsigned P_CLK        = 1;
	localparam int unsigned P_CSI        = 2;
	localparam int unsigned P_RST        = 3;
	localparam int unsigned P_CTL        = 4;
	localparam int unsigned P_BYTE_EN    = 7;
	localparam int unsigned P_BUS        = 8;
	localparam int unsigned PIN_W        = 16;
	// pin levels while idle: select in rests high, all others low
	localparam logic [15:0] PIN_IDLE     = 16'h0004;
	// power mode register zero fields
	localparam int unsigned B_UNIT_EN    = 1;
	localparam int unsigned B_TURBO_OFF  = 3;
	localparam int unsigned B_ARRAY_CLK  = 4;
	localparam int unsigned B_MCELL_CLK  = 5;
	localparam logic [7:0]  PMR0_MASK    = 8'h3a;
	// power mode register two fields
	localparam int unsigned B_CTL0_OFF   = 2;
	localparam int unsigned B_STB_OFF    = 5;
	localparam int unsigned B_BYTE_OFF   = 6;
	localparam logic [7:0]  PMR2_MASK    = 8'h7c;
	// reset values and idle count
	localparam logic [7:0]  PMR_RESET    = 8'h00;
	localparam logic [3:0]  CNT_RESET    = 4'h0;
	localparam logic [3:0]  CNT_STEP     = 4'h1;
	localparam logic [3:0]  PD_COUNT     = 4'hf;
endpackage

// File: inactivity_sleep_unit.sv
// inactivity sleep unit: idle counter, power-down flag, bus gating, signal blocking
// assumes pins are asynchronous to i_clk and mode writes come from logic on i_clk
//
// Summary of operation
// R1: memories wake only on input change, then standby
// R2: enabled unit counts count-clock edges after strobe stops
// R3: fifteen idle count periods raise the power-down flag
// R4: unit enable alone makes power-down available
// R5: strobe, select low or reset high exits
// R6: power-down gates bus and deselects memories
// R7: count clock block never stops idle counter
// R8: power-down leaves logic arrays running normally
// R9: power-down tri-states data port, address undefined
// R10: select high disables memories, not arrays
// R11: mcu writes modes; blocking bits stop signals
// R12: turbo default on; off allows array standby
// R13: toggling array inputs keep arrays awake only
// R14: register zero bit 1 enables the unit
// R15: register zero bit 3 turns turbo off
// R16: register two bits 2-6 block array inputs
// R17: mode bits cleared at power-up only
// R18: strobe pulse clears the idle counter
`timescale 1ns/100ps
module inactivity_sleep_unit
	import sleep_unit_pkg::*;
(
	input  wire logic       i_clk,                 // 10 MHz system clock
	input  wire logic       i_arst_n,              // power-up reset, active low
	input  wire logic       i_address_strobe_pin,  // mcu address strobe
	input  wire logic       i_count_clock_input,   // count clock pin
	input  wire logic       i_select_port_pin_n,   // chip select in, active low
	input  wire logic       i_reset_pin,           // device reset pin, active high
	input  wire logic [2:0] i_ctrl,                // mcu control inputs 0..2
	input  wire logic       i_data_byte_enable_input, // data byte enable
	input  wire logic [7:0] i_bus,                 // mcu address/data bus
	input  wire logic       i_pmr0_wr,             // write strobe, register zero
	input  wire logic       i_pmr2_wr,             // write strobe, register two
	input  wire logic [7:0] i_wdata,               // write data
	output logic [7:0]      o_power_mode_reg_zero, // register zero readback
	output logic [7:0]      o_power_mode_reg_two,  // register two readback
	output logic            o_power_down_flag,     // power-down mode
	output logic [3:0]      o_idle_count,          // idle counter value
	output logic [7:0]      o_mem_bus,             // bus as seen by memories
	output logic            o_mem_select,          // memories and io block selected
	output logic            o_mem_wake,            // memory wake pulse
	output logic [7:0]      o_pld_bus,             // bus as seen by arrays
	output logic [2:0]      o_pld_ctrl,            // control inputs to arrays
	output logic            o_pld_strobe,          // strobe to arrays
	output logic            o_pld_byte_en,         // byte enable to arrays
	output logic            o_pld_array_clk,       // count clock to and array
	output logic            o_pld_mcell_clk,       // count clock to macrocells
	output logic            o_turbo_on,            // arrays at full speed
	output logic            o_pld_standby,         // arrays at standby current
	output logic            o_data_port_tristate,  // data and peripheral pins off
	output logic            o_addr_out_undefined   // latched address pins undefined
);

	// all state of the block
	typedef struct packed {
		logic [PIN_W-1:0] sync1;      // first synchroniser stage
		logic [PIN_W-1:0] sync2;      // second synchroniser stage
		logic [PIN_W-1:0] prev;       // previous synchronised pins
		logic [7:0]       pmr0;       // power mode register zero
		logic [7:0]       pmr2;       // power mode register two
		logic [3:0]       cnt;        // idle counter
		logic             pd;         // power-down flag
		logic [7:0]       mem_bus;    // latched memory bus
		logic             mem_sel;    // memory select
		logic             mem_wake;   // memory wake pulse
		logic [7:0]       pld_bus;    // array bus
		logic [2:0]       pld_ctrl;   // array control inputs
		logic             pld_strobe; // array strobe
		logic             pld_byte_en; // array byte enable
		logic             pld_aclk;   // array clock
		logic             pld_mclk;   // macrocell clock
		logic             pld_stby;   // array standby
		logic             turbo;      // arrays at full speed
	} state_t;

	// power-up state: pins at idle level so no false exit, modes clear, turbo on [R17] [R12]
	localparam state_t Q_RESET = '{sync1: PIN_IDLE, sync2: PIN_IDLE, prev: PIN_IDLE,
		turbo: 1'b1, default: '0};

	state_t q;                         // registered state
	state_t d;                         // next state

	// rising edge of a synchronised level
	function automatic logic rise(input logic prev, input logic cur);
		rise = cur & ~prev;
	endfunction

	// any bit of a group changed
	function automatic logic changed(input logic [15:0] a, input logic [15:0] b);
		changed = (a != b);
	endfunction

	logic stb_edge;                    // strobe pulse seen
	logic clk_edge;                    // count clock period seen
	logic wake;                        // any exit condition
	logic unit_en;                     // unit enabled

	// next-state logic
	always_comb begin
		d = q;
		d.sync1 = {i_bus, i_data_byte_enable_input, i_ctrl, i_reset_pin,
			i_select_port_pin_n, i_count_clock_input, i_address_strobe_pin};
		d.sync2 = q.sync1;
		d.prev = q.sync2;
		stb_edge = rise(q.prev[P_STB], q.sync2[P_STB]);
		// counter sees the raw count clock, never the blocked copy [R7]
		clk_edge = rise(q.prev[P_CLK], q.sync2[P_CLK]);
		unit_en = q.pmr0[B_UNIT_EN]; // [R14] [R4]
		wake = stb_edge | ~q.sync2[P_CSI] | q.sync2[P_RST]; // [R5]
		// mode writes, unused bits forced to zero; reset pin leaves them alone [R11] [R17]
		if (i_pmr0_wr) begin
			d.pmr0 = i_wdata & PMR0_MASK;
		end
		if (i_pmr2_wr) begin
			d.pmr2 = i_wdata & PMR2_MASK;
		end
		// turbo flop follows register zero bit 3 in the cycle of the write
		d.turbo = ~d.pmr0[B_TURBO_OFF]; // [R15]
		// idle counter and power-down flag; exit conditions win over counting
		if (!unit_en || wake) begin
			d.cnt = CNT_RESET; // [R18] [R5]
			d.pd = 1'b0;
		end else if (clk_edge && q.cnt != PD_COUNT) begin
			d.cnt = q.cnt + CNT_STEP; // [R2]
			if (d.cnt == PD_COUNT) begin
				d.pd = 1'b1; // [R3]
			end
		end
		// memory side: bus frozen and memories deselected in power-down [R6]
		// select high deselects memories and io block only [R10]
		d.mem_sel = ~q.sync2[P_CSI] & ~d.pd;
		if (!d.pd) begin
			d.mem_bus = q.sync2[P_BUS +: 8];
		end
		// one-cycle wake on a gated input change, standby otherwise [R1] [R13]
		d.mem_wake = d.mem_sel && (d.mem_bus != q.mem_bus);
		// array inputs: bus gated in power-down, rest only by blocking bits [R6] [R8]
		if (!d.pd) begin
			d.pld_bus = q.sync2[P_BUS +: 8];
		end
		for (int i = 0; i < 3; i++) begin
			d.pld_ctrl[i] = q.sync2[P_CTL + i] & ~q.pmr2[B_CTL0_OFF + i]; // [R16]
		end
		d.pld_strobe = q.sync2[P_STB] & ~q.pmr2[B_STB_OFF]; // [R16]
		d.pld_byte_en = q.sync2[P_BYTE_EN] & ~q.pmr2[B_BYTE_OFF]; // [R16]
		d.pld_aclk = q.sync2[P_CLK] & ~q.pmr0[B_ARRAY_CLK]; // [R11]
		d.pld_mclk = q.sync2[P_CLK] & ~q.pmr0[B_MCELL_CLK]; // [R11]
		// standby only with turbo off and no unblocked input moving [R12] [R15] [R13]
		d.pld_stby = q.pmr0[B_TURBO_OFF] && !changed(
			{d.pld_bus, d.pld_ctrl, d.pld_strobe, d.pld_byte_en, d.pld_aclk, d.pld_mclk, 1'b0},
			{q.pld_bus, q.pld_ctrl, q.pld_strobe, q.pld_byte_en, q.pld_aclk, q.pld_mclk, 1'b0});
	end

	// state register; power-up clears modes, counter and flag, loads pins at idle level, turbo on by default [R17] [R12]
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			q <= Q_RESET;
		end else begin
			q <= d;
		end
	end

	// outputs straight from flops
	assign o_power_mode_reg_zero = q.pmr0;
	assign o_power_mode_reg_two  = q.pmr2;
	assign o_power_down_flag     = q.pd;
	assign o_idle_count          = q.cnt;
	assign o_mem_bus             = q.mem_bus;
	assign o_mem_select          = q.mem_sel;
	assign o_mem_wake            = q.mem_wake;
	assign o_pld_bus             = q.pld_bus;
	assign o_pld_ctrl            = q.pld_ctrl;
	assign o_pld_strobe          = q.pld_strobe;
	assign o_pld_byte_en         = q.pld_byte_en;
	assign o_pld_array_clk       = q.pld_aclk;
	assign o_pld_mcell_clk       = q.pld_mclk;
	assign o_turbo_on            = q.turbo; // [R15]
	assign o_pld_standby         = q.pld_stby;
	// port effects of power-down [R9]
	assign o_data_port_tristate  = q.pd;
	assign o_addr_out_undefined  = q.pd;

	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	pd_entry_a: assert property ($rose(q.pd) |-> q.cnt == PD_COUNT && $past(q.cnt) == 4'he) // [R3]
		else $error("power-down raised without fifteen idle periods");
	cnt_step_a: assert property (unit_en && clk_edge && !wake && q.cnt < 4'he // [R2]
		|=> q.cnt == $past(q.cnt) + 4'h1)
		else $error("idle counter failed to advance");
	clk_block_a: assert property (q.pmr0[B_ARRAY_CLK] && unit_en // [R7]
		&& clk_edge && !wake && q.cnt != PD_COUNT |=> q.cnt != $past(q.cnt))
		else $error("blocked array clock stopped the idle counter");
	exit_reset_a: assert property (q.pd && q.sync2[P_RST] |=> !q.pd ##1 !q.pd) // [R5]
		else $error("reset pin did not leave power-down");
	strobe_clr_a: assert property (stb_edge |=> q.cnt == 4'h0 && !q.pd) // [R18]
		else $error("strobe pulse did not clear the idle counter");
	unit_off_a: assert property (!q.pmr0[B_UNIT_EN] |=> !q.pd) // [R14]
		else $error("power-down while unit disabled");
	bus_gate_a: assert property (q.pd && $past(q.pd) |-> $stable(q.mem_bus) && !q.mem_sel) // [R6]
		else $error("memory bus moved or selected in power-down");
	select_off_a: assert property (q.sync2[P_CSI] |=> !q.mem_sel && !q.mem_wake) // [R10]
		else $error("memories selected with select pin high");
	block_ctl_a: assert property (q.pmr2[B_CTL0_OFF] |=> !q.pld_ctrl[0]) // [R16]
		else $error("blocked control input reached the arrays");
	turbo_stby_a: assert property (!q.pmr0[B_TURBO_OFF] |=> !q.pld_stby) // [R12]
		else $error("array standby with turbo on");
	mode_keep_a: assert property (q.sync2[P_RST] && !i_pmr0_wr && !i_pmr2_wr // [R17]
		|=> $stable(q.pmr0) && $stable(q.pmr2))
		else $error("reset pin altered mode registers");
	clk_gate_a: assert property (q.pmr0[B_ARRAY_CLK] |=> !q.pld_aclk) // [R11]
		else $error("blocked count clock reached the and array");
	mclk_pass_a: assert property (!q.pmr0[B_MCELL_CLK] // [R11]
		|=> q.pld_mclk == $past(q.sync2[P_CLK]))
		else $error("unblocked count clock missing at the macrocells");

	enter_pd_c: cover property ($rose(q.pd));
	strobe_exit_c: cover property (q.pd ##1 stb_edge ##1 !q.pd);
	pld_stby_c: cover property (q.pd && q.pld_stby);
	mem_wake_c: cover property (q.mem_wake ##1 !q.mem_wake);
endmodule

// File: mcu_model.sv
// mcu side model: count clock source and address strobe pulses
// assumes the bench commands it just after rising edges of i_clk
`timescale 1ns/100ps
module mcu_model (
	input  wire logic i_clk,       // system clock
	input  wire logic i_arst_n,    // reset, active low
	input  wire logic i_run,       // count clock runs while high
	input  wire logic i_stb_req,   // request one strobe pulse
	output logic      o_count_clk, // two cycles high, two low; stands low when idle
	output logic      o_strobe     // address strobe, three cycles high
);
	logic [1:0] ph_q; // count clock phase
	logic [1:0] sl_q; // strobe cycles left
	// slow clock and strobe, both registered so the dut sees clean levels
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ph_q <= 2'h0;
			sl_q <= 2'h0;
			o_count_clk <= 1'b0;
			o_strobe <= 1'b0;
		end else begin
			ph_q <= i_run ? ph_q + 2'h1 : 2'h0;
			o_count_clk <= i_run & (ph_q == 2'h1 || ph_q == 2'h2);
			sl_q <= i_stb_req ? 2'h3 : sl_q - 2'(sl_q != 2'h0);
			o_strobe <= sl_q != 2'h0;
		end
	end
endmodule

// File: tb.sv
// bench for the inactivity sleep unit: mode writes, sleep entry, exits, blocking
// assumes the mcu model drives strobe and count clock; one 10 MHz clock
`timescale 1ns/100ps
module tb;
	import sleep_unit_pkg::*;
	logic clk = 0, arst_n = 0, run = 0, req = 0, sel_n = 1, rst = 0, w0 = 0, w2 = 0;
	logic byte_en = 0;
	logic [2:0] ctrl = 3'h0, p_ctrl;
	logic [7:0] bus = 8'h5a, wd = 8'h00, r0, r2, m_bus, p_bus;
	logic [3:0] cnt;
	logic stb, ck, pd, m_sel, wake, p_stb, p_byte, p_ac, p_mc, turbo, stby, tri_s, undef;
	int n_mismatch = 0, total_checks = 0, ticks = 0;
	mcu_model mcu (.i_clk(clk), .i_arst_n(arst_n), .i_run(run), .i_stb_req(req),
		.o_count_clk(ck), .o_strobe(stb));
	inactivity_sleep_unit dut (.i_clk(clk), .i_arst_n(arst_n), .i_address_strobe_pin(stb),
		.i_count_clock_input(ck), .i_select_port_pin_n(sel_n), .i_reset_pin(rst),
		.i_ctrl(ctrl), .i_data_byte_enable_input(byte_en), .i_bus(bus), .i_pmr0_wr(w0),
		.i_pmr2_wr(w2), .i_wdata(wd), .o_power_mode_reg_zero(r0), .o_power_mode_reg_two(r2),
		.o_power_down_flag(pd), .o_idle_count(cnt), .o_mem_bus(m_bus), .o_mem_select(m_sel),
		.o_mem_wake(wake), .o_pld_bus(p_bus), .o_pld_ctrl(p_ctrl), .o_pld_strobe(p_stb),
		.o_pld_byte_en(p_byte), .o_pld_array_clk(p_ac), .o_pld_mcell_clk(p_mc),
		.o_turbo_on(turbo),
		.o_pld_standby(stby), .o_data_port_tristate(tri_s), .o_addr_out_undefined(undef));
	// 100 ns clock
	initial begin
		forever #50 clk = ~clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one-cycle write strobe to register zero or two
	task automatic wr(input logic two, input logic [7:0] d);
		@(posedge clk);
		w0 <= !two; w2 <= two; wd <= d;
		@(posedge clk);
		w0 <= 1'b0; w2 <= 1'b0;
		cyc(3);
	endtask
	// n whole count clock periods, then let the sync stages settle
	task automatic per(input int n);
		@(posedge clk);
		run <= 1'b1;
		cyc(4 * n);
		run <= 1'b0;
		cyc(6);
	endtask
	task automatic t_reset;
		chk("reg0", r0, PMR_RESET);
		chk("reg2", r2, PMR_RESET);
		chk("turbo", 8'(turbo), 8'h01);
		chk("flag", 8'(pd), 8'h00);
	endtask
	// unused bits read 0; turbo off lets quiet arrays idle; reset pin keeps modes
	task automatic t_regs;
		wr(1'b0, 8'hff);
		wr(1'b1, 8'hff);
		chk("reg0", r0, 8'h3a);
		chk("reg2", r2, 8'h7c);
		chk("turbo", 8'(turbo), 8'h00);
		chk("standby", 8'(stby), 8'h01);
		@(posedge clk) rst <= 1'b1;
		cyc(6);
		rst <= 1'b0;
		chk("reg0 kept", r0, 8'h3a);
		wr(1'b0, 8'h00);
		wr(1'b1, 8'h00);
		chk("turbo on", 8'(turbo), 8'h01);
	endtask
	// select gating, fifteen idle periods, then what power-down blocks and keeps
	task automatic t_sleep;
		@(posedge clk) sel_n <= 1'b0;
		cyc(5);
		chk("selected", 8'(m_sel), 8'h01);
		// selected memories wake for one cycle on a bus change
		@(posedge clk) bus <= 8'h69;
		cyc(4);
		chk("wake", 8'(wake), 8'h01);
		@(posedge clk);
		chk("wake once", 8'(wake), 8'h00);
		@(posedge clk) sel_n <= 1'b1;
		bus <= 8'h3c;
		cyc(5);
		chk("deselected", 8'(m_sel), 8'h00);
		chk("pld bus", p_bus, 8'h3c);
		wr(1'b0, 8'h02);
		per(14);
		chk("count 14", 8'(cnt), 8'h0e);
		chk("flag early", 8'(pd), 8'h00);
		per(1);
		chk("count 15", 8'(cnt), 8'(PD_COUNT));
		chk("flag", 8'(pd), 8'h01);
		chk("tristate", {6'h0, tri_s, undef}, 8'h03);
		@(posedge clk) bus <= 8'ha5;
		ctrl <= 3'h5;
		cyc(6);
		chk("mem bus", m_bus, 8'h3c);
		chk("pld bus held", p_bus, 8'h3c);
		chk("mem sel", {7'h0, m_sel | wake}, 8'h00);
		chk("pld ctrl", 8'(p_ctrl), 8'h05);
	endtask
	// each exit condition in turn, re-entering power-down before the second and third
	task automatic t_exits;
		for (int k = 0; k < 3; k++) begin
			if (k > 0) per(15);
			chk("flag in", 8'(pd), 8'h01);
			@(posedge clk);
			req <= k == 0; sel_n <= k != 1; rst <= k == 2;
			bus <= 8'hc0 | 8'(k);
			@(posedge clk) req <= 1'b0;
			cyc(8);
			chk("flag out", 8'(pd), 8'h00);
			chk("count out", 8'(cnt), 8'(CNT_RESET));
			chk("bus open", p_bus, 8'hc0 | 8'(k));
			chk("mem bus open", m_bus, 8'hc0 | 8'(k));
			@(posedge clk) sel_n <= 1'b1;
			rst <= 1'b0;
			cyc(4);
		end
	endtask
	// blocking bits stop array inputs; blocked count clock still counts
	task automatic t_block;
		wr(1'b1, 8'h7c);
		wr(1'b0, 8'h12);
		@(posedge clk) ctrl <= 3'h7;
		byte_en <= 1'b1;
		req <= 1'b1;
		@(posedge clk) req <= 1'b0;
		cyc(5);
		chk("blocked", {4'h0, p_ctrl, p_byte | p_stb}, 8'h00);
		per(15);
		chk("flag", 8'(pd), 8'h01);
		// six cycles of count clock: macrocells see it, the and array does not
		@(posedge clk) run <= 1'b1;
		cyc(6);
		chk("clocks", {6'h0, p_ac, p_mc}, 8'h01);
		run <= 1'b0;
		cyc(6);
		wr(1'b1, 8'h00);
		chk("open", {4'h0, p_ctrl, p_byte}, 8'h0f);
		// turbo off in power-down: moving control inputs keep the arrays awake
		wr(1'b0, 8'h1a);
		repeat (6) @(posedge clk) ctrl <= ~ctrl;
		chk("stby moving", 8'(stby), 8'h00);
		cyc(6);
		chk("stby quiet", 8'(stby), 8'h01);
		chk("mem asleep", {6'h0, pd, m_sel | wake}, 8'h02);
	endtask
	task automatic wrap_up;
		if (n_mismatch == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// hang guard
	always @(posedge clk) begin
		ticks++;
		if (ticks == 5000) begin
			n_mismatch++;
			wrap_up;
		end
	end
	initial begin
		cyc(16);
		arst_n <= 1'b1;
		cyc(2);
		t_reset;
		t_regs;
		t_sleep;
		t_exits;
		t_block;
		wrap_up;
	end
endmodule
